/* File: wkc_pkg.sv */
// wkc_pkg: register map, field layout and timing constants of the wakeup comparator control.
// assumes a 20 MHz peripheral clock and a 32-bit Avalon-MM register port.
`default_nettype none
package wkc_pkg;
	localparam logic [11:0] OFF_START_TASK = 12'h000;
	localparam logic [11:0] OFF_STOP_TASK = 12'h004;
	localparam logic [11:0] OFF_SAMPLE_TASK = 12'h008;
	localparam logic [11:0] OFF_READY_EVENT = 12'h100;
	localparam logic [11:0] OFF_DOWNWARD_EVENT = 12'h104;
	localparam logic [11:0] OFF_UPWARD_EVENT = 12'h108;
	localparam logic [11:0] OFF_CROSSING_EVENT = 12'h10c;
	localparam logic [11:0] OFF_SHORTCUTS = 12'h200;
	localparam logic [11:0] OFF_INT_ENABLE = 12'h300;
	localparam logic [11:0] OFF_INT_ENABLE_SET = 12'h304;
	localparam logic [11:0] OFF_INT_ENABLE_CLEAR = 12'h308;
	localparam logic [11:0] OFF_COMPARE_RESULT = 12'h400;
	localparam logic [11:0] OFF_ENABLE = 12'h500;
	localparam logic [11:0] OFF_INPUT_PIN_SELECT = 12'h504;
	localparam logic [11:0] OFF_REFERENCE_SELECT = 12'h508;
	localparam logic [11:0] OFF_EXT_REFERENCE_SELECT = 12'h50c;
	localparam logic [11:0] OFF_WAKE_SOURCE_CONFIG = 12'h520;
	localparam logic [11:0] OFF_HYSTERESIS_ENABLE = 12'h538;
	localparam logic [11:0] OFF_STATUS = 12'h600;

	// event bit order inside the interrupt enable registers
	localparam int EV_READY = 0;
	localparam int EV_DOWN = 1;
	localparam int EV_UP = 2;
	localparam int EV_CROSSING_EVENT = 3;
	localparam int NUM_EVENTS = 4;

	// shortcut bit positions
	localparam int SC_READY_SAMPLE = 0;
	localparam int SC_READY_STOP = 1;
	localparam int SC_DOWN_STOP = 2;
	localparam int SC_UP_STOP = 3;
	localparam int SC_CROSSING_TO_STOP_LINK = 4;
	localparam int SC_WIDTH = 5;

	localparam int PSEL_WIDTH = 3;
	localparam int REFERENCE_SELECT_WIDTH = 4;
	localparam int WAKESEL_WIDTH = 2;

	// wake source encodings
	localparam logic [1:0] WAKE_CROSSING_EVENT = 2'h0;
	localparam logic [1:0] WAKE_UP = 2'h1;
	localparam logic [1:0] WAKE_DOWN = 2'h2;

	localparam logic [PSEL_WIDTH-1:0] PSEL_RESET = 3'h0;
	localparam logic [REFERENCE_SELECT_WIDTH-1:0] REFERENCE_SELECT_RESET = 4'h4;
	localparam logic [WAKESEL_WIDTH-1:0] WAKESEL_RESET = 2'h0;

	localparam int CLK_HZ = 20000000;
	localparam int STARTUP_US = 140;
	localparam int STARTUP_CYCLES = (STARTUP_US * (CLK_HZ / 1000000));
	localparam int STARTUP_CNT_WIDTH = 12;

	typedef enum logic [1:0] {ST_IDLE, ST_STARTING, ST_RUNNING} wkc_state_type;

	typedef struct packed {
		logic [PSEL_WIDTH-1:0] pin;
		logic [REFERENCE_SELECT_WIDTH-1:0] ref_sel;
		logic ext_ref;
		logic hysteresis_enable;
	} wkc_analog_cfg_type;
endpackage
`default_nettype wire

/* File: wkc_ctrl.sv */
// wkc_ctrl: control of a low-power wakeup comparator; tasks, events, shortcuts, wake signal, registers.
// assumes an Avalon-MM master on CLK, the analog core output arriving asynchronously on CMP_OUT,
// and SRST pulsed by the power manager on wake from system-off.
//
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module wkc_ctrl #(
	parameter int STARTUP_CYCLES = wkc_pkg::STARTUP_CYCLES
) (
	input wire logic CLK, // 20 MHz peripheral clock
	input wire logic SRST, // synchronous reset, high; also pulsed on wake from system-off
	input wire logic [11:0] AVS_ADDRESS, // byte address
	input wire logic AVS_READ, // read request
	input wire logic AVS_WRITE, // write request
	input wire logic [31:0] AVS_WRITEDATA, // write data
	input wire logic [3:0] AVS_BYTEENABLE, // byte lanes
	output logic [31:0] AVS_READDATA, // read data
	output logic AVS_WAITREQUEST, // stall
	output logic [1:0] AVS_RESPONSE, // 00 ok, 10 slave error
	input wire logic CMP_OUT, // analog core output, asynchronous
	input wire logic SYSTEM_OFF, // power manager says system is off
	output logic CORE_ENABLE, // powers the analog core
	output logic PIN_CLAIM, // selected analog pins acquired
	output wkc_pkg::wkc_analog_cfg_type CORE_CFG, // pin, reference, hysteresis to the core
	output logic ANALOG_WAKE, // wake request to the power manager
	output logic IRQ // interrupt request
);
	logic cmp_meta_r, cmp_sync_r, cmp_prev_r;
	logic ack_r;
	wkc_pkg::wkc_state_type state_r;
	logic [wkc_pkg::STARTUP_CNT_WIDTH-1:0] cnt_r;
	logic [wkc_pkg::NUM_EVENTS-1:0] ev_r, inten_r;
	logic [wkc_pkg::SC_WIDTH-1:0] event_task_shortcuts_r;
	logic enable_r, result_r;
	wkc_pkg::wkc_analog_cfg_type cfg_r;
	logic [wkc_pkg::WAKESEL_WIDTH-1:0] wakesel_r;
	logic [31:0] rdata_nxt;
	logic mapped;
	logic wr, rd, wr_one;
	logic ready_pulse, up_pulse, down_pulse, crossing_event_pulse;
	logic start_trig, stop_trig, sample_trig;
	logic running;
	logic [wkc_pkg::NUM_EVENTS-1:0] ev_set, ev_clr;

	// one-cycle bus answer: waitrequest high in the first cycle of a request, low in the second
	assign wr = AVS_WRITE && ack_r;
	assign rd = AVS_READ && ack_r;
	assign wr_one = AVS_BYTEENABLE[0] && AVS_WRITEDATA[0];

	always_ff @(posedge CLK) begin
		if (SRST) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= (AVS_READ || AVS_WRITE) && !ack_r;
		end
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			cmp_meta_r <= 1'b0;
			cmp_sync_r <= 1'b0;
			cmp_prev_r <= 1'b0;
		end else begin
			cmp_meta_r <= CMP_OUT;
			cmp_sync_r <= cmp_meta_r;
			cmp_prev_r <= cmp_sync_r;
		end
	end

	assign running = (state_r == wkc_pkg::ST_RUNNING);
	assign up_pulse = running && cmp_sync_r && !cmp_prev_r;
	assign down_pulse = running && !cmp_sync_r && cmp_prev_r;
	assign crossing_event_pulse = up_pulse || down_pulse;
	assign ready_pulse = (state_r == wkc_pkg::ST_STARTING)
		&& (cnt_r == wkc_pkg::STARTUP_CNT_WIDTH'(STARTUP_CYCLES - 1));

	assign start_trig = wr && (AVS_ADDRESS == wkc_pkg::OFF_START_TASK) && wr_one && enable_r;
	assign sample_trig = (wr && (AVS_ADDRESS == wkc_pkg::OFF_SAMPLE_TASK) && wr_one)
		|| (ready_pulse && event_task_shortcuts_r[wkc_pkg::SC_READY_SAMPLE]);
	assign stop_trig = (wr && (AVS_ADDRESS == wkc_pkg::OFF_STOP_TASK) && wr_one)
		|| (ready_pulse && event_task_shortcuts_r[wkc_pkg::SC_READY_STOP])
		|| (down_pulse && event_task_shortcuts_r[wkc_pkg::SC_DOWN_STOP])
		|| (up_pulse && event_task_shortcuts_r[wkc_pkg::SC_UP_STOP])
		|| (crossing_event_pulse && event_task_shortcuts_r[wkc_pkg::SC_CROSSING_TO_STOP_LINK]);

	// stop wins over a start in the same cycle
	always_ff @(posedge CLK) begin
		if (SRST) begin
			state_r <= wkc_pkg::ST_IDLE;
			cnt_r <= '0;
		end else if (stop_trig || !enable_r) begin
			state_r <= wkc_pkg::ST_IDLE;
			cnt_r <= '0;
		end else begin
			unique case (state_r)
				wkc_pkg::ST_IDLE: begin
					if (start_trig) begin
						state_r <= wkc_pkg::ST_STARTING;
						cnt_r <= '0;
					end
				end
				wkc_pkg::ST_STARTING: begin
					if (ready_pulse) begin
						state_r <= wkc_pkg::ST_RUNNING;
					end else begin
						cnt_r <= cnt_r + 1'b1;
					end
				end
				wkc_pkg::ST_RUNNING: begin
					state_r <= wkc_pkg::ST_RUNNING;
				end
			endcase
		end
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			result_r <= 1'b0;
		end else if (sample_trig) begin
			result_r <= cmp_sync_r;
		end
	end

	// events are suppressed while the system is off; only the wake line moves then
	assign ev_set[wkc_pkg::EV_READY] = ready_pulse && !SYSTEM_OFF;
	assign ev_set[wkc_pkg::EV_DOWN] = down_pulse && !SYSTEM_OFF;
	assign ev_set[wkc_pkg::EV_UP] = up_pulse && !SYSTEM_OFF;
	assign ev_set[wkc_pkg::EV_CROSSING_EVENT] = crossing_event_pulse && !SYSTEM_OFF;

	genvar g;
	generate
		for (g = 0; g < wkc_pkg::NUM_EVENTS; g++) begin : g_ev
			assign ev_clr[g] = wr && (AVS_ADDRESS == (wkc_pkg::OFF_READY_EVENT + 12'(4 * g)))
				&& AVS_BYTEENABLE[0] && !AVS_WRITEDATA[0];
			always_ff @(posedge CLK) begin
				if (SRST) begin
					ev_r[g] <= 1'b0;
				end else if (ev_set[g]) begin
					ev_r[g] <= 1'b1;
				end else if (ev_clr[g]) begin
					ev_r[g] <= 1'b0;
				end
			end
		end
	endgenerate

	always_ff @(posedge CLK) begin
		if (SRST) begin
			inten_r <= '0;
		end else if (wr && AVS_BYTEENABLE[0] && (AVS_ADDRESS == wkc_pkg::OFF_INT_ENABLE_SET)) begin
			inten_r <= inten_r | AVS_WRITEDATA[wkc_pkg::NUM_EVENTS-1:0];
		end else if (wr && AVS_BYTEENABLE[0] && (AVS_ADDRESS == wkc_pkg::OFF_INT_ENABLE_CLEAR)) begin
			inten_r <= inten_r & ~AVS_WRITEDATA[wkc_pkg::NUM_EVENTS-1:0];
		end else if (wr && AVS_BYTEENABLE[0] && (AVS_ADDRESS == wkc_pkg::OFF_INT_ENABLE)) begin
			inten_r <= AVS_WRITEDATA[wkc_pkg::NUM_EVENTS-1:0];
		end
	end

	// configuration; all state returns to reset values on SRST, which the wake from system-off drives
	always_ff @(posedge CLK) begin
		if (SRST) begin
			event_task_shortcuts_r <= '0;
			enable_r <= 1'b0;
			cfg_r.pin <= wkc_pkg::PSEL_RESET;
			cfg_r.ref_sel <= wkc_pkg::REFERENCE_SELECT_RESET;
			cfg_r.ext_ref <= 1'b0;
			cfg_r.hysteresis_enable <= 1'b0;
			wakesel_r <= wkc_pkg::WAKESEL_RESET;
		end else if (wr && AVS_BYTEENABLE[0]) begin
			unique case (AVS_ADDRESS)
				wkc_pkg::OFF_SHORTCUTS: event_task_shortcuts_r <= AVS_WRITEDATA[wkc_pkg::SC_WIDTH-1:0];
				wkc_pkg::OFF_ENABLE: enable_r <= AVS_WRITEDATA[0];
				wkc_pkg::OFF_INPUT_PIN_SELECT: cfg_r.pin <= AVS_WRITEDATA[wkc_pkg::PSEL_WIDTH-1:0];
				wkc_pkg::OFF_REFERENCE_SELECT: cfg_r.ref_sel <= AVS_WRITEDATA[wkc_pkg::REFERENCE_SELECT_WIDTH-1:0];
				wkc_pkg::OFF_EXT_REFERENCE_SELECT: cfg_r.ext_ref <= AVS_WRITEDATA[0];
				wkc_pkg::OFF_WAKE_SOURCE_CONFIG: wakesel_r <= AVS_WRITEDATA[wkc_pkg::WAKESEL_WIDTH-1:0];
				wkc_pkg::OFF_HYSTERESIS_ENABLE: cfg_r.hysteresis_enable <= AVS_WRITEDATA[0];
				default: event_task_shortcuts_r <= event_task_shortcuts_r;
			endcase
		end
	end

	// outputs to core and power manager; pins are claimed and config latched while enabled
	always_ff @(posedge CLK) begin
		if (SRST) begin
			CORE_ENABLE <= 1'b0;
			PIN_CLAIM <= 1'b0;
			CORE_CFG <= '0;
			ANALOG_WAKE <= 1'b0;
			IRQ <= 1'b0;
		end else begin
			CORE_ENABLE <= enable_r && (state_r != wkc_pkg::ST_IDLE || SYSTEM_OFF);
			PIN_CLAIM <= enable_r;
			if (!PIN_CLAIM) begin
				CORE_CFG <= cfg_r;
			end
			unique case (wakesel_r)
				wkc_pkg::WAKE_UP: ANALOG_WAKE <= up_pulse && SYSTEM_OFF;
				wkc_pkg::WAKE_DOWN: ANALOG_WAKE <= down_pulse && SYSTEM_OFF;
				default: ANALOG_WAKE <= crossing_event_pulse && SYSTEM_OFF;
			endcase
			IRQ <= |(ev_r & inten_r);
		end
	end

	always_comb begin
		mapped = 1'b1;
		rdata_nxt = '0;
		unique case (AVS_ADDRESS)
			wkc_pkg::OFF_START_TASK, wkc_pkg::OFF_STOP_TASK, wkc_pkg::OFF_SAMPLE_TASK: rdata_nxt = '0;
			wkc_pkg::OFF_READY_EVENT: rdata_nxt[0] = ev_r[wkc_pkg::EV_READY];
			wkc_pkg::OFF_DOWNWARD_EVENT: rdata_nxt[0] = ev_r[wkc_pkg::EV_DOWN];
			wkc_pkg::OFF_UPWARD_EVENT: rdata_nxt[0] = ev_r[wkc_pkg::EV_UP];
			wkc_pkg::OFF_CROSSING_EVENT: rdata_nxt[0] = ev_r[wkc_pkg::EV_CROSSING_EVENT];
			wkc_pkg::OFF_SHORTCUTS: rdata_nxt[wkc_pkg::SC_WIDTH-1:0] = event_task_shortcuts_r;
			wkc_pkg::OFF_INT_ENABLE, wkc_pkg::OFF_INT_ENABLE_SET, wkc_pkg::OFF_INT_ENABLE_CLEAR:
				rdata_nxt[wkc_pkg::NUM_EVENTS-1:0] = inten_r;
			wkc_pkg::OFF_COMPARE_RESULT: rdata_nxt[0] = result_r;
			wkc_pkg::OFF_ENABLE: rdata_nxt[0] = enable_r;
			wkc_pkg::OFF_INPUT_PIN_SELECT: rdata_nxt[wkc_pkg::PSEL_WIDTH-1:0] = cfg_r.pin;
			wkc_pkg::OFF_REFERENCE_SELECT: rdata_nxt[wkc_pkg::REFERENCE_SELECT_WIDTH-1:0] = cfg_r.ref_sel;
			wkc_pkg::OFF_EXT_REFERENCE_SELECT: rdata_nxt[0] = cfg_r.ext_ref;
			wkc_pkg::OFF_WAKE_SOURCE_CONFIG: rdata_nxt[wkc_pkg::WAKESEL_WIDTH-1:0] = wakesel_r;
			wkc_pkg::OFF_HYSTERESIS_ENABLE: rdata_nxt[0] = cfg_r.hysteresis_enable;
			wkc_pkg::OFF_STATUS: rdata_nxt[2:0] = {cmp_sync_r, running, state_r == wkc_pkg::ST_STARTING};
			default: mapped = 1'b0;
		endcase
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			AVS_READDATA <= '0;
			AVS_RESPONSE <= 2'h0;
			AVS_WAITREQUEST <= 1'b1;
		end else begin
			AVS_WAITREQUEST <= !((AVS_READ || AVS_WRITE) && !ack_r && !AVS_WAITREQUEST ? 1'b0 :
				((AVS_READ || AVS_WRITE) && !ack_r));
			AVS_READDATA <= (AVS_READ && !ack_r) ? rdata_nxt : 32'h0;
			AVS_RESPONSE <= ((AVS_READ || AVS_WRITE) && !ack_r && !mapped) ? 2'h2 : 2'h0;
		end
	end
endmodule // wkc_ctrl
`default_nettype wire

/* File: wkc_ctrl_asserts.sv */
// wkc_ctrl_asserts: port-level checks of the wakeup comparator control, bound to wkc_ctrl.
// assumes a single CLK domain and SRST synchronous active high.
`timescale 1ns/10ps
`default_nettype none
module wkc_ctrl_asserts (
	input wire logic CLK, // clock
	input wire logic SRST, // reset
	input wire logic [11:0] AVS_ADDRESS, // byte address
	input wire logic AVS_READ, // read request
	input wire logic AVS_WRITE, // write request
	input wire logic [31:0] AVS_WRITEDATA, // write data
	input wire logic [3:0] AVS_BYTEENABLE, // byte lanes
	input wire logic [31:0] AVS_READDATA, // read data
	input wire logic AVS_WAITREQUEST, // stall
	input wire logic [1:0] AVS_RESPONSE, // response code
	input wire logic SYSTEM_OFF, // system off
	input wire logic CORE_ENABLE, // core power
	input wire logic PIN_CLAIM, // pins acquired
	input wire wkc_pkg::wkc_analog_cfg_type CORE_CFG, // core selection
	input wire logic ANALOG_WAKE, // wake request
	input wire logic IRQ // interrupt
);
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (SRST);
	logic go_w;
	// a write accepted at this edge with lane 0 on
	assign go_w = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0];
	chk_wait_one: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
		else $error("waitrequest low for more than one cycle");
	chk_req_answer: assert property ($rose(AVS_READ || AVS_WRITE) |=> !AVS_WAITREQUEST)
		else $error("request not answered after one wait cycle");
	chk_idle_data: assert property (AVS_WAITREQUEST |-> AVS_READDATA == 32'h0 && AVS_RESPONSE == 2'h0)
		else $error("read data or response outside the answer cycle");
	chk_reset_outs: assert property ($fell(SRST) |-> AVS_WAITREQUEST && !IRQ && !PIN_CLAIM && !CORE_ENABLE)
		else $error("outputs not at reset values after reset");
	chk_wake_off: assert property (ANALOG_WAKE |-> SYSTEM_OFF || $past(SYSTEM_OFF))
		else $error("wake signal outside system off");
	chk_wake_core: assert property (ANALOG_WAKE |-> $past(CORE_ENABLE))
		else $error("wake signal with core disabled");
	chk_wake_pulse: assert property (ANALOG_WAKE |=> !ANALOG_WAKE)
		else $error("wake signal longer than one cycle");
	chk_cfg_frozen: assert property (PIN_CLAIM && $past(PIN_CLAIM) |-> $stable(CORE_CFG))
		else $error("core selection changed while pins claimed");
	chk_claim_enable: assert property (go_w && AVS_ADDRESS == wkc_pkg::OFF_ENABLE |-> ##2 PIN_CLAIM == $past(AVS_WRITEDATA[0], 2))
		else $error("pin claim does not follow enable write");
	chk_stop_halts: assert property (go_w && AVS_ADDRESS == wkc_pkg::OFF_STOP_TASK && AVS_WRITEDATA[0] && !SYSTEM_OFF |-> ##[1:3] !CORE_ENABLE)
		else $error("stop task did not halt the core");
endmodule // wkc_ctrl_asserts
bind wkc_ctrl wkc_ctrl_asserts wkc_ctrl_asserts_inst (.CLK(CLK), .SRST(SRST), .AVS_ADDRESS(AVS_ADDRESS),
	.AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
	.AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .AVS_RESPONSE(AVS_RESPONSE),
	.SYSTEM_OFF(SYSTEM_OFF), .CORE_ENABLE(CORE_ENABLE), .PIN_CLAIM(PIN_CLAIM), .CORE_CFG(CORE_CFG),
	.ANALOG_WAKE(ANALOG_WAKE), .IRQ(IRQ));
`default_nettype wire

/* File: wkc_core_model.sv */
// wkc_core_model: behavioural analog comparator core on the far side of the control block.
// assumes the bench says through vin_above whether the input sits above the reference.
`timescale 1ns/10ps
`default_nettype none
module wkc_core_model (
	input wire logic clk, // paces the idle pattern
	input wire logic core_enable, // core powered
	input wire wkc_pkg::wkc_analog_cfg_type core_cfg, // selection, not modelled
	input wire logic vin_above, // input above reference
	output var logic cmp_out // comparator decision
);
	// an unpowered core gives no valid decision, so the output wanders
	initial cmp_out = 1'b0;
	always @(posedge clk) begin
		cmp_out <= core_enable ? vin_above : ~cmp_out;
	end
endmodule // wkc_core_model
`default_nettype wire

/* File: wkc_ctrl_tb.sv */
// wkc_ctrl_tb: register table loop, then start, crossings, sample, shortcuts, wake and wake reset.
// assumes wkc_core_model stands for the analog core; startup count cut to 20 cycles.
`timescale 1ns/10ps
`default_nettype none
module wkc_ctrl_tb;
	localparam int SU = 20;
	typedef struct packed {
		logic [11:0] a;
		logic [31:0] pre;
		logic [31:0] wr;
		logic [31:0] ex;
		logic [1:0] rp;
	} wkc_row_type;
	wkc_row_type rows [11] = '{'{12'h100, 32'h0, 32'h0, 32'h0, 2'h0}, '{12'h10c, 32'h0, 32'h0, 32'h0, 2'h0},
		'{12'h200, 32'h0, 32'h1f, 32'h1f, 2'h0}, '{12'h504, 32'h0, 32'h5, 32'h5, 2'h0},
		'{12'h508, 32'h4, 32'h9, 32'h9, 2'h0}, '{12'h50c, 32'h0, 32'h1, 32'h1, 2'h0},
		'{12'h520, 32'h0, 32'h1, 32'h1, 2'h0}, '{12'h538, 32'h0, 32'h1, 32'h1, 2'h0},
		'{12'h400, 32'h0, 32'h1, 32'h0, 2'h0}, '{12'h304, 32'h0, 32'hf, 32'hf, 2'h0},
		'{12'h308, 32'hf, 32'h3, 32'hc, 2'h0}};
	logic clk, avs_waitrequest, cmp_out, core_enable, pin_claim, analog_wake, irq;
	logic srst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, sys_off = 1'b0, vin = 1'b0;
	logic [11:0] avs_address = 12'h0;
	logic [3:0] avs_byteenable = 4'hf;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
	logic [1:0] avs_response, rs;
	wkc_pkg::wkc_analog_cfg_type core_cfg;
	int err_count = 0, total_checks = 0, cyc = 0, n;
	wkc_ctrl #(.STARTUP_CYCLES(SU)) wkc_ctrl_inst (.CLK(clk), .SRST(srst), .AVS_ADDRESS(avs_address),
		.AVS_READ(avs_read), .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(avs_byteenable),
		.AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest), .AVS_RESPONSE(avs_response),
		.CMP_OUT(cmp_out), .SYSTEM_OFF(sys_off), .CORE_ENABLE(core_enable), .PIN_CLAIM(pin_claim),
		.CORE_CFG(core_cfg), .ANALOG_WAKE(analog_wake), .IRQ(irq));
	wkc_core_model wkc_core_model_inst (.clk(clk), .core_enable(core_enable), .core_cfg(core_cfg),
		.vin_above(vin), .cmp_out(cmp_out));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task results;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			err_count++;
			results();
		end
	end
	task chk(input logic [31:0] got, input logic [31:0] ex);
		total_checks++;
		if (got !== ex) begin
			$display("BAD t=%0t got=%h exp=%h", $time, got, ex);
			err_count++;
		end
	endtask
	// one request held until waitrequest is sampled low, then a gap cycle
	task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_write <= w;
		avs_read <= ~w;
		avs_writedata <= d;
		do begin
			@(posedge clk);
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		rs = avs_response;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clk);
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task rd(input logic [11:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(q, e);
	endtask
	task clrf;
		for (int i = 1; i < 4; i++) wr(12'h100 + 12'(4 * i), 32'h0);
	endtask
	task watch(output int c);
		c = 0;
		repeat (12) begin
			@(posedge clk);
			if (analog_wake === 1'b1) c++;
		end
	endtask
	initial begin
		repeat (5) @(posedge clk);
		srst <= 1'b0;
		foreach (rows[i]) begin
			rd(rows[i].a, rows[i].pre);
			wr(rows[i].a, rows[i].wr);
			rd(rows[i].a, rows[i].ex);
			chk({30'h0, rs}, {30'h0, rows[i].rp});
		end
		rd(12'h7f0, 32'h0);
		chk({30'h0, rs}, 32'h2);
		wr(12'h200, 32'h0);
		wr(12'h500, 32'h1);
		repeat (2) @(posedge clk);
		chk({31'h0, pin_claim}, 32'h1);
		chk({23'h0, core_cfg}, {23'h0, 3'h5, 4'h9, 2'h3});
		wr(12'h000, 32'h1);
		repeat (SU - 6) @(posedge clk);
		rd(12'h100, 32'h0);
		repeat (8) @(posedge clk);
		rd(12'h100, 32'h1);
		clrf();
		vin <= 1'b1;
		repeat (6) @(posedge clk);
		rd(12'h108, 32'h1);
		rd(12'h10c, 32'h1);
		rd(12'h104, 32'h0);
		chk({31'h0, irq}, 32'h1);
		clrf();
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h0);
		rd(12'h108, 32'h0);
		vin <= 1'b0;
		repeat (6) @(posedge clk);
		rd(12'h104, 32'h1);
		rd(12'h10c, 32'h1);
		rd(12'h108, 32'h0);
		wr(12'h008, 32'h1);
		rd(12'h400, 32'h0);
		vin <= 1'b1;
		repeat (6) @(posedge clk);
		wr(12'h008, 32'h1);
		rd(12'h400, 32'h1);
		wr(12'h200, 32'h4);
		clrf();
		vin <= 1'b0;
		repeat (6) @(posedge clk);
		chk({31'h0, core_enable}, 32'h0);
		clrf();
		vin <= 1'b1;
		repeat (6) @(posedge clk);
		rd(12'h108, 32'h0);
		wr(12'h004, 32'h1);
		wr(12'h200, 32'h3);
		vin <= 1'b0;
		wr(12'h000, 32'h1);
		repeat (SU + 8) @(posedge clk);
		chk({31'h0, core_enable}, 32'h0);
		rd(12'h400, 32'h0);
		wr(12'h200, 32'h10);
		wr(12'h000, 32'h1);
		repeat (SU + 8) @(posedge clk);
		clrf();
		chk({31'h0, core_enable}, 32'h1);
		vin <= 1'b1;
		repeat (6) @(posedge clk);
		chk({31'h0, core_enable}, 32'h0);
		wr(12'h200, 32'h0);
		vin <= 1'b0;
		wr(12'h000, 32'h1);
		repeat (SU + 8) @(posedge clk);
		clrf();
		sys_off <= 1'b1;
		vin <= 1'b1;
		watch(n);
		chk(32'(n), 32'h1);
		vin <= 1'b0;
		watch(n);
		chk(32'(n), 32'h0);
		rd(12'h108, 32'h0);
		rd(12'h10c, 32'h0);
		sys_off <= 1'b0;
		wr(12'h004, 32'h1);
		wr(12'h500, 32'h0);
		@(posedge clk);
		chk({31'h0, pin_claim}, 32'h0);
		wr(12'h500, 32'h1);
		srst <= 1'b1;
		@(posedge clk);
		srst <= 1'b0;
		rd(12'h500, 32'h0);
		rd(12'h508, 32'h4);
		chk({31'h0, pin_claim}, 32'h0);
		avs_byteenable <= 4'he;
		wr(12'h538, 32'h1);
		avs_byteenable <= 4'hf;
		rd(12'h538, 32'h0);
		results();
	end
endmodule // wkc_ctrl_tb
`default_nettype wire
